// *** spi_eeprom_command_engine.sv ***
// Purpose: command front end of a 64 KiB serial eeprom behind an spi link
// Assumes: sck_i only toggles while cs_n_i is low; mode 0
// Notes: link logic runs on sck_i, array and self-timed cycles on ref_clk_i
//
// Notes on behaviour
// - capture si on rising sck into opcode
// - all bytes travel msb first
// - decode array read and array write
// - decode latch set and latch clear
// - decode status read and status write
// - recognise page, sector, chip wipe
// - recognise signature release and deep sleep
// - read: opcode, 16-bit address, data out
// - read pointer advances, wraps at top
// - select rising ends the read
// - latch sets only on exact frame
// - write up to 128 bytes, one page
// - page index wraps inside the page
// - short write keeps untouched page bytes
// - commit only right after last d0
// - status readable during write cycle
// - no array data while busy
// - latch clears at reset and commits
// - status bit 0 shows busy
// - status bit 1 mirrors latch
// - protect bits and pin enable layout
// - pause freezes and resumes the link
// - pin plus enable blocks status write
// - protect code selects top region

`timescale 1ns/1ns

module spi_eeprom_command_engine #(
  parameter int unsigned WRITE_CYCLES = eeprom_cmd_pkg::WRITE_CYCLE_CYCLES,
  parameter int unsigned ERASE_CYCLES = eeprom_cmd_pkg::ERASE_CYCLE_CYCLES,
  parameter logic [7:0] SIG_BYTE = 8'h3C // arbitrary value
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic hold_n_i,
  input wire logic si_i,
  input wire logic wp_n_i,
  output logic so_o,
  output logic so_oe_n_o,
  output logic busy_o
);
  import eeprom_cmd_pkg::*;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // frame ended on a byte boundary after exactly n bytes
  function automatic logic exact(input frame_t f, input logic [7:0] n);
    return (f.nbytes == n) && f.aligned;
  endfunction

  // address lies in the protected region
  function automatic logic prot_hit(input logic [15:0] a,
                                    input logic [1:0] bp);
    logic hit;
    hit = 1'b0;
    case (bp)
      2'h1: hit = (a >= QUARTER_BASE);
      2'h2: hit = (a >= HALF_BASE);
      2'h3: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // what the link does after the opcode byte
  function automatic link_state_t decode_op(input logic [7:0] op,
                                            input logic sleeping);
    link_state_t ns;
    ns = LS_IGNORE;
    if (!sleeping || op == SIGNATURE_RELEASE_CMD) begin
      case (op)
        READ_CMD, WRITE_CMD: ns = LS_ADDR;
        PAGE_WIPE_CMD, SECTOR_WIPE_CMD: ns = LS_ADDR;
        SIGNATURE_RELEASE_CMD: ns = LS_ADDR;
        STATUS_READ_CMD, STATUS_WRITE_CMD: ns = LS_STAT;
        default: ns = LS_IGNORE;
      endcase
    end
    return ns;
  endfunction

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [7:0] mem [MEM_BYTES];
  logic [7:0] pbuf [PAGE_BYTES];

  // ---------------------------------------------------------------
  // link side declarations
  // ---------------------------------------------------------------
  logic frame_rst;
  logic active_q;
  logic drive_q;
  logic tog_q;
  logic [2:0] bit_q;
  logic [7:0] sh_q;
  logic [7:0] opcode_q;
  logic [7:0] nbytes_q;
  logic [7:0] out_q;
  logic [15:0] addr_q;
  link_state_t state_q;
  logic [PAGE_BYTES-1:0] pmask_q;
  dev_view_t view_s1_q;
  dev_view_t view_s2_q;
  dev_view_t view_w;
  logic so_q;
  logic so_oe_n_q;
  logic first;
  logic byte_done;
  logic [2:0] bit_d;
  logic [7:0] byte_in;
  logic [7:0] nb_base;
  logic [7:0] nb_d;
  logic [15:0] addr_in;
  logic [15:0] rd_addr;
  link_state_t cur_state;
  logic opc_done;
  logic addr_done;
  logic data_done;
  logic load_rd;
  logic load_sig;
  logic load_st;
  logic pg_wr;
  logic pm_clr;
  logic sleep_s;
  logic busy_s;
  logic latch_s;

  // ---------------------------------------------------------------
  // link side: bit and byte bookkeeping
  // ---------------------------------------------------------------
  // cs high ends the frame with no further sck edge
  assign frame_rst = rst_i | cs_n_i;
  assign first = !active_q;
  assign cur_state = first ? LS_OPC : state_q;
  assign bit_d = first ? 3'h1 : bit_q + 3'h1;
  assign byte_done = (bit_d == 3'h0);
  assign byte_in = {sh_q[6:0], si_i};
  assign nb_base = first ? 8'h00 : nbytes_q;
  assign nb_d = (byte_done && nb_base != NBYTES_MAX) ?
                nb_base + 8'h01 : nb_base;
  assign addr_in = {addr_q[14:0], si_i};
  assign rd_addr = (cur_state == LS_ADDR) ? addr_in : addr_q;
  assign sleep_s = view_s2_q.sleep;
  assign busy_s = view_s2_q.status[BUSY_BIT];
  assign latch_s = view_s2_q.status[LATCH_BIT];

  // byte events for the output shifter and page buffer
  assign opc_done = (cur_state == LS_OPC) && byte_done;
  assign addr_done = (cur_state == LS_ADDR) && byte_done &&
                     (nb_d == ADDR_END_BYTES);
  assign data_done = (cur_state == LS_DATA) && byte_done;
  assign load_rd = (addr_done || data_done) && (opcode_q == READ_CMD);
  assign load_sig = (addr_done || data_done) &&
                    (opcode_q == SIGNATURE_RELEASE_CMD);
  assign load_st = (opc_done && byte_in == STATUS_READ_CMD && !sleep_s) ||
                   ((cur_state == LS_STAT) && byte_done &&
                    (opcode_q == STATUS_READ_CMD));
  assign pg_wr = data_done && (opcode_q == WRITE_CMD) &&
                 latch_s && !busy_s;
  assign pm_clr = opc_done && (byte_in == WRITE_CMD) && !busy_s;

  // frame-start marker and output drive, dropped by cs high
  always_ff @(posedge sck_i or posedge frame_rst) begin
    if (frame_rst) begin
      active_q <= 1'b0;
      drive_q <= 1'b0;
    end else if (hold_n_i) begin
      active_q <= 1'b1;
      if (load_rd) begin
        drive_q <= !busy_s;
      end else if (load_sig || load_st) begin
        drive_q <= 1'b1;
      end
    end
  end

  // frame contents survive cs high for the core side
  always_ff @(posedge sck_i or posedge rst_i) begin
    if (rst_i) begin
      tog_q <= 1'b0;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      nbytes_q <= 8'h00;
      opcode_q <= 8'h00;
      addr_q <= 16'h0000;
      state_q <= LS_OPC;
    end else if (hold_n_i) begin
      if (first) begin
        tog_q <= !tog_q;
      end
      bit_q <= bit_d;
      sh_q <= byte_in;
      nbytes_q <= nb_d;
      if (opc_done) begin
        opcode_q <= byte_in;
        state_q <= decode_op(byte_in, sleep_s);
      end else if (addr_done) begin
        state_q <= LS_DATA;
      end else begin
        state_q <= cur_state;
      end
      if (cur_state == LS_ADDR) begin
        addr_q <= addr_in;
      end
      if (load_rd) begin
        addr_q <= rd_addr + 16'h0001;
      end
      if (pg_wr) begin
        addr_q[PAGE_W-1:0] <= addr_q[PAGE_W-1:0] + 7'h01;
      end
    end
  end

  // output shifter: reload per byte, else shift msb first
  always_ff @(posedge sck_i or posedge rst_i) begin
    if (rst_i) begin
      out_q <= 8'h00;
    end else if (hold_n_i) begin
      if (load_rd) begin
        out_q <= mem[rd_addr];
      end else if (load_sig) begin
        out_q <= SIG_BYTE;
      end else if (load_st) begin
        out_q <= view_s2_q.status;
      end else begin
        out_q <= {out_q[6:0], 1'b0};
      end
    end
  end

  // page buffer and its byte-supplied mask
  always_ff @(posedge sck_i) begin
    if (hold_n_i && pg_wr) begin
      pbuf[addr_q[PAGE_W-1:0]] <= byte_in;
    end
  end

  // the mask only clears once busy is seen low, so a running copy
  // never has its source changed underneath it
  always_ff @(posedge sck_i or posedge rst_i) begin
    if (rst_i) begin
      pmask_q <= '0;
    end else if (hold_n_i) begin
      if (pm_clr) begin
        pmask_q <= '0;
      end else if (pg_wr) begin
        pmask_q[addr_q[PAGE_W-1:0]] <= 1'b1;
      end
    end
  end

  // core state into the link domain; status fields move rarely
  always_ff @(posedge sck_i or posedge rst_i) begin
    if (rst_i) begin
      view_s1_q <= '0;
      view_s2_q <= '0;
    end else begin
      view_s1_q <= view_w;
      view_s2_q <= view_s1_q;
    end
  end

  // so changes on the falling edge, valid by the next rise
  always_ff @(negedge sck_i or posedge frame_rst) begin
    if (frame_rst) begin
      so_q <= 1'b0;
      so_oe_n_q <= 1'b1;
    end else if (hold_n_i) begin
      so_q <= out_q[7];
      so_oe_n_q <= !drive_q;
    end
  end

  assign so_o = so_q;
  assign so_oe_n_o = so_oe_n_q | !hold_n_i;

  // ---------------------------------------------------------------
  // core side declarations
  // ---------------------------------------------------------------
  logic cs_s1_q, cs_s2_q, cs_s3_q;
  logic wp_s1_q, wp_s2_q;
  logic seen_tog_q;
  logic busy_q, latch_q, ppe_q, sleep_q;
  logic [1:0] bp_q;
  logic job_run_q, job_buf_q;
  logic [15:0] job_addr_q, job_last_q;
  logic [TIMER_W-1:0] timer_q;
  frame_t fr;
  logic new_frame, cycle_end;
  logic go, go_buf, st_wr, lat_set, lat_clr, sleep_set, sleep_clr;
  logic [15:0] go_span;
  logic [15:0] go_base;
  logic [TIMER_W-1:0] go_cycles;

  // ---------------------------------------------------------------
  // core side: select and pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      wp_s1_q <= 1'b1;
      wp_s2_q <= 1'b1;
    end else if (clk_en_i) begin
      cs_s1_q <= cs_n_i;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      wp_s1_q <= wp_n_i;
      wp_s2_q <= wp_s1_q;
    end
  end

  // sck is idle once select is high, so the frame fields are stable
  // when the synchronised rise arrives and need no further crossing
  assign fr = '{opcode: opcode_q, nbytes: nbytes_q,
                aligned: (bit_q == 3'h0), last_byte: sh_q, addr: addr_q};
  assign new_frame = cs_s2_q && !cs_s3_q && (tog_q != seen_tog_q);
  assign cycle_end = busy_q && (timer_q == '0) && !job_run_q;
  assign go_base = fr.addr & ~go_span;

  // ---------------------------------------------------------------
  // core side: command commit on select rising
  // ---------------------------------------------------------------
  always_comb begin
    go = 1'b0;
    go_buf = 1'b0;
    go_span = PAGE_SPAN;
    go_cycles = TIMER_W'(WRITE_CYCLES);
    st_wr = 1'b0;
    lat_set = 1'b0;
    lat_clr = 1'b0;
    sleep_set = 1'b0;
    sleep_clr = 1'b0;
    if (new_frame && (!sleep_q || fr.opcode == SIGNATURE_RELEASE_CMD)) begin
      case (fr.opcode)
        LATCH_SET_CMD: lat_set = exact(fr, OPC_ONLY_BYTES);
        LATCH_CLEAR_CMD: lat_clr = exact(fr, OPC_ONLY_BYTES);
        STATUS_WRITE_CMD: begin
          st_wr = exact(fr, STAT_WR_BYTES) && latch_q && !busy_q &&
                  !(ppe_q && !wp_s2_q);
        end
        WRITE_CMD: begin
          go = (fr.nbytes >= FIRST_DATA_BYTES) && fr.aligned &&
               latch_q && !busy_q &&
               !prot_hit(fr.addr & ~PAGE_SPAN, bp_q);
          go_buf = 1'b1;
        end
        PAGE_WIPE_CMD: begin
          go = exact(fr, ADDR_END_BYTES) && latch_q && !busy_q &&
               !prot_hit(fr.addr & ~PAGE_SPAN, bp_q);
        end
        SECTOR_WIPE_CMD: begin
          go = exact(fr, ADDR_END_BYTES) && latch_q && !busy_q &&
               !prot_hit(fr.addr & ~SECTOR_SPAN, bp_q);
          go_span = SECTOR_SPAN;
          go_cycles = TIMER_W'(ERASE_CYCLES);
        end
        CHIP_WIPE_CMD: begin
          go = exact(fr, OPC_ONLY_BYTES) && latch_q && !busy_q &&
               (bp_q == 2'h0);
          go_span = ARRAY_SPAN;
          go_cycles = TIMER_W'(ERASE_CYCLES);
        end
        DEEP_SLEEP_CMD: sleep_set = exact(fr, OPC_ONLY_BYTES) && !busy_q;
        SIGNATURE_RELEASE_CMD: sleep_clr = 1'b1;
        default: lat_clr = 1'b0;
      endcase
    end
  end

  // write latch: set wins over a simultaneous clear
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      latch_q <= 1'b0;
    end else if (clk_en_i) begin
      if (lat_set) begin
        latch_q <= 1'b1;
      end else if (lat_clr || st_wr || go || cycle_end) begin
        latch_q <= 1'b0;
      end
    end
  end

  // protect bits, pin enable, sleep and frame bookkeeping
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bp_q <= BP_RESET;
      ppe_q <= PPE_RESET;
      sleep_q <= 1'b0;
      seen_tog_q <= 1'b0;
    end else if (clk_en_i) begin
      if (new_frame) begin
        seen_tog_q <= tog_q;
      end
      if (st_wr) begin
        bp_q <= fr.last_byte[BP_HI_BIT:BP_LO_BIT];
        ppe_q <= fr.last_byte[PPE_BIT];
      end
      if (sleep_set) begin
        sleep_q <= 1'b1;
      end else if (sleep_clr) begin
        sleep_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // core side: self-timed cycle and array update
  // ---------------------------------------------------------------
  // busy covers the timer and the byte copy, whichever is longer
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
      timer_q <= '0;
      job_run_q <= 1'b0;
      job_buf_q <= 1'b0;
      job_addr_q <= 16'h0000;
      job_last_q <= 16'h0000;
    end else if (clk_en_i) begin
      if (go) begin
        busy_q <= 1'b1;
        timer_q <= go_cycles;
        job_run_q <= 1'b1;
        job_buf_q <= go_buf;
        job_addr_q <= go_base;
        job_last_q <= go_base | go_span;
      end else begin
        if (timer_q != '0) begin
          timer_q <= timer_q - 1'b1;
        end
        if (cycle_end) begin
          busy_q <= 1'b0;
        end
        if (job_run_q) begin
          if (job_addr_q == job_last_q) begin
            job_run_q <= 1'b0;
          end else begin
            job_addr_q <= job_addr_q + 16'h0001;
          end
        end
      end
    end
  end

  // unsupplied page bytes are left as they were, which is the same
  // as rewriting them with their old contents
  always_ff @(posedge ref_clk_i) begin
    if (clk_en_i && job_run_q) begin
      if (!job_buf_q) begin
        mem[job_addr_q] <= ERASED_BYTE;
      end else if (pmask_q[job_addr_q[PAGE_W-1:0]]) begin
        mem[job_addr_q] <= pbuf[job_addr_q[PAGE_W-1:0]];
      end
    end
  end

  // status byte as seen by a status read
  always_comb begin
    view_w = '0;
    view_w.sleep = sleep_q;
    view_w.status[BUSY_BIT] = busy_q;
    view_w.status[LATCH_BIT] = latch_q;
    view_w.status[BP_HI_BIT:BP_LO_BIT] = bp_q;
    view_w.status[PPE_BIT] = ppe_q;
  end

  assign busy_o = busy_q;

endmodule

// *** eeprom_cmd_pkg.sv ***
// Purpose: shared constants and types for the serial eeprom command engine
// Assumes: 64 KiB array, 128-byte pages, 16 KiB sectors, 100 MHz ref clock
// Notes: every opcode, bit position and cycle count lives here

package eeprom_cmd_pkg;

  // ---------------------------------------------------------------
  // opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] READ_CMD = 8'h03;
  localparam logic [7:0] WRITE_CMD = 8'h02;
  localparam logic [7:0] LATCH_SET_CMD = 8'h06;
  localparam logic [7:0] LATCH_CLEAR_CMD = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD = 8'h05;
  localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] PAGE_WIPE_CMD = 8'h42;
  localparam logic [7:0] SECTOR_WIPE_CMD = 8'hD8;
  localparam logic [7:0] CHIP_WIPE_CMD = 8'hC7;
  localparam logic [7:0] SIGNATURE_RELEASE_CMD = 8'hAB;
  localparam logic [7:0] DEEP_SLEEP_CMD = 8'hB9;

  // ---------------------------------------------------------------
  // array geometry and protection boundaries
  // ---------------------------------------------------------------
  localparam int unsigned MEM_BYTES = 65536;
  localparam int unsigned PAGE_BYTES = 128;
  localparam int unsigned PAGE_W = 7;
  localparam logic [15:0] PAGE_SPAN = 16'h007F;
  localparam logic [15:0] SECTOR_SPAN = 16'h3FFF;
  localparam logic [15:0] ARRAY_SPAN = 16'hFFFF;
  localparam logic [15:0] QUARTER_BASE = 16'hC000;
  localparam logic [15:0] HALF_BASE = 16'h8000;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // ---------------------------------------------------------------
  // status register layout
  // ---------------------------------------------------------------
  localparam int unsigned BUSY_BIT = 0;
  localparam int unsigned LATCH_BIT = 1;
  localparam int unsigned BP_LO_BIT = 2;
  localparam int unsigned BP_HI_BIT = 3;
  localparam int unsigned PPE_BIT = 7;
  localparam logic [1:0] BP_RESET = 2'h0;
  localparam logic PPE_RESET = 1'b0;

  // ---------------------------------------------------------------
  // byte counts that mark a complete frame
  // ---------------------------------------------------------------
  localparam logic [7:0] OPC_ONLY_BYTES = 8'h01;
  localparam logic [7:0] STAT_WR_BYTES = 8'h02;
  localparam logic [7:0] ADDR_END_BYTES = 8'h03;
  localparam logic [7:0] FIRST_DATA_BYTES = 8'h04;
  localparam logic [7:0] NBYTES_MAX = 8'hFF;

  // ---------------------------------------------------------------
  // self-timed cycle lengths
  // ---------------------------------------------------------------
  localparam int unsigned REF_CLK_HZ = 100_000_000;
  localparam int unsigned WRITE_CYCLE_MS = 5;
  localparam int unsigned ERASE_CYCLE_MS = 10;
  localparam int unsigned WRITE_CYCLE_CYCLES =
    WRITE_CYCLE_MS * (REF_CLK_HZ / 1000);
  localparam int unsigned ERASE_CYCLE_CYCLES =
    ERASE_CYCLE_MS * (REF_CLK_HZ / 1000);
  localparam int unsigned TIMER_W = 20;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    LS_OPC = 3'h0,
    LS_ADDR = 3'h1,
    LS_DATA = 3'h3,
    LS_STAT = 3'h2,
    LS_IGNORE = 3'h6
  } link_state_t;

  // frame summary left behind by the link side for the core side
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] nbytes;
    logic aligned;
    logic [7:0] last_byte;
    logic [15:0] addr;
  } frame_t;

  // core state mirrored into the link side
  typedef struct packed {
    logic sleep;
    logic [7:0] status;
  } dev_view_t;

endpackage

// *** eeprom_cmd_properties.sv ***
// Purpose: port-level checks of the eeprom command engine
// Assumes: mode 0 link, select high resets the link side
// Notes: bound to the top module; mirror runs on the link clock
`timescale 1ns/1ns
module eeprom_cmd_properties #(
  parameter int unsigned WRITE_CYCLES = 300
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic hold_n_i,
  input wire logic si_i,
  input wire logic so_o,
  input wire logic so_oe_n_o,
  input wire logic busy_o
);
  import eeprom_cmd_pkg::*;
  logic [7:0] opc_q;
  logic [5:0] bits_q;
  int unsigned busy_cnt_q;
  logic known;
  logic unsel;
  // --------------------------------------------------------------
  // frame mirror and busy length
  // --------------------------------------------------------------
  // saturate at 32 so long reads cannot wrap
  always_ff @(posedge sck_i or posedge cs_n_i or posedge rst_i) begin
    if (cs_n_i || rst_i) begin
      bits_q <= 6'h00;
      opc_q <= 8'h00;
    end else if (hold_n_i) begin
      if (bits_q < 6'h20) bits_q <= bits_q + 6'h01;
      if (bits_q < 6'h08) opc_q <= {opc_q[6:0], si_i};
    end
  end
  // cycles spent busy
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) busy_cnt_q <= 32'h0;
    else busy_cnt_q <= busy_o ? busy_cnt_q + 32'h1 : 32'h0;
  end
  assign unsel = rst_i || cs_n_i;
  assign known = opc_q inside {READ_CMD, WRITE_CMD, LATCH_SET_CMD,
    LATCH_CLEAR_CMD, STATUS_READ_CMD, STATUS_WRITE_CMD, PAGE_WIPE_CMD,
    SECTOR_WIPE_CMD, CHIP_WIPE_CMD, SIGNATURE_RELEASE_CMD, DEEP_SLEEP_CMD};
  sequence cycle_run_s;
    busy_o [*8];
  endsequence
  sel_hiz_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cs_n_i |-> so_oe_n_o) else $error("so driven while deselected");
  pause_hiz_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !hold_n_i |-> so_oe_n_o) else $error("so driven during pause");
  commit_edge_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $rose(busy_o) |-> $past(cs_n_i) && $past(cs_n_i, 2))
    else $error("busy began while selected");
  busy_run_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $rose(busy_o) |-> cycle_run_s) else $error("busy pulse too short");
  busy_min_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $fell(busy_o) |-> busy_cnt_q >= WRITE_CYCLES)
    else $error("self-timed cycle ended early");
  opc_quiet_a: assert property (@(posedge sck_i) disable iff (unsel)
    bits_q < 6'h08 |-> so_oe_n_o) else $error("so driven in opcode");
  addr_quiet_a: assert property (@(posedge sck_i) disable iff (unsel)
    opc_q == READ_CMD && bits_q < 6'h18 |-> so_oe_n_o)
    else $error("so driven before address done");
  status_any_a: assert property (@(posedge sck_i) disable iff (unsel)
    opc_q == STATUS_READ_CMD && bits_q >= 6'h08 && hold_n_i |-> !so_oe_n_o)
    else $error("status not driven");
  busy_read_a: assert property (@(posedge sck_i) disable iff (unsel)
    opc_q == READ_CMD && busy_o |-> so_oe_n_o)
    else $error("array data while busy");
  unknown_quiet_a: assert property (@(posedge sck_i) disable iff (unsel)
    bits_q >= 6'h08 && !known |-> so_oe_n_o)
    else $error("unknown opcode answered");
endmodule
bind spi_eeprom_command_engine eeprom_cmd_properties #(
  .WRITE_CYCLES(WRITE_CYCLES)) u_eeprom_cmd_properties (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sck_i(sck_i), .cs_n_i(cs_n_i),
  .hold_n_i(hold_n_i), .si_i(si_i), .so_o(so_o), .so_oe_n_o(so_oe_n_o),
  .busy_o(busy_o));

// *** spi_host_model.sv ***
// Purpose: host side of the serial link, mode 0
// Assumes: link clock stands low outside frames
// Notes: a released data line reads back inverted
`timescale 1ns/1ns
module spi_host_model (
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o,
  output logic hold_n_o,
  input wire logic so_i,
  input wire logic so_oe_n_i
);
  logic line;
  assign line = so_oe_n_i ? ~so_i : so_i;
  // two link edges inside reset clear the link flops
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    hold_n_o = 1'b1;
    repeat (2) begin
      #20 sck_o <= 1'b1;
      #20 sck_o <= 1'b0;
    end
  end
  task automatic sel();
    #40 cs_n_o <= 1'b0;
    #60;
  endtask
  // gap covers disable time and the commit sync
  task automatic desel();
    #70 cs_n_o <= 1'b1;
    #160;
  endtask
  task automatic xfer(input logic [7:0] tx, input int n,
                      output logic [7:0] rx);
    for (int i = 7; i > 7 - n; i--) begin
      si_o <= tx[i];
      #62 sck_o <= 1'b1;
      rx[i] = line;
      #63 sck_o <= 1'b0;
    end
  endtask
  // pause between bytes; the clock keeps running
  task automatic pause();
    #30 hold_n_o <= 1'b0;
    repeat (2) begin
      #62 sck_o <= 1'b1;
      #63 sck_o <= 1'b0;
    end
    #30 hold_n_o <= 1'b1;
    #30;
  endtask
endmodule

// *** spi_eeprom_command_engine_tb.sv ***
// Purpose: self-checking bench for the eeprom command engine
// Assumes: short self-timed cycles
// Notes: link traffic comes from the host model
`timescale 1ns/1ns
module spi_eeprom_command_engine_tb;
  import eeprom_cmd_pkg::*;
  localparam int unsigned CYC = 1000;
  localparam logic [7:0] SIG = 8'h5E; // arbitrary value
  logic ref_clk_i, rst_i, wp_n_i, sck, cs_n, si, hold_n, so, so_oe_n, busy;
  logic [7:0] rx;
  int fail_count, cmp_count;
  spi_eeprom_command_engine #(.WRITE_CYCLES(CYC), .ERASE_CYCLES(CYC),
    .SIG_BYTE(SIG)) u_spi_eeprom_command_engine (.ref_clk_i(ref_clk_i),
    .rst_i(rst_i), .clk_en_i(1'b1), .sck_i(sck), .cs_n_i(cs_n),
    .hold_n_i(hold_n), .si_i(si), .wp_n_i(wp_n_i), .so_o(so),
    .so_oe_n_o(so_oe_n), .busy_o(busy));
  spi_host_model u_spi_host_model (.sck_o(sck), .cs_n_o(cs_n), .si_o(si),
    .hold_n_o(hold_n), .so_i(so), .so_oe_n_i(so_oe_n));
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  task automatic stop_test();
    if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic on();
    u_spi_host_model.sel();
  endtask
  task automatic off();
    u_spi_host_model.desel();
  endtask
  task automatic snd(input logic [7:0] b);
    u_spi_host_model.xfer(b, 8, rx);
  endtask
  task automatic cmd(input logic [7:0] op);
    on();
    snd(op);
    off();
  endtask
  task automatic stat(input logic [7:0] exp);
    on();
    snd(STATUS_READ_CMD);
    snd(8'h00);
    chk(rx, exp);
    off();
  endtask
  task automatic hdr(input logic [7:0] op, input logic [15:0] a);
    on();
    snd(op);
    snd(a[15:8]);
    snd(a[7:0]);
  endtask
  task automatic wr(input logic [15:0] a, input logic [23:0] d, input int n);
    cmd(LATCH_SET_CMD);
    hdr(WRITE_CMD, a);
    for (int i = n - 1; i >= 0; i--) snd(d[8*i +: 8]);
    off();
  endtask
  task automatic rd(input logic [15:0] a, input logic [23:0] d, input int n);
    hdr(READ_CMD, a);
    for (int i = n - 1; i >= 0; i--) begin
      snd(8'h00);
      chk(rx, d[8*i +: 8]);
    end
    off();
  endtask
  task automatic idle();
    for (int i = 0; i < 70000 && busy !== 1'b0; i++) @(posedge ref_clk_i);
    chk(8'(busy), 8'h00);
  endtask
  task automatic swr(input logic [7:0] v);
    cmd(LATCH_SET_CMD);
    on();
    snd(STATUS_WRITE_CMD);
    snd(v);
    off();
  endtask
  task automatic t_latch();
    stat(8'h00);
    cmd(LATCH_SET_CMD);
    stat(8'h02);
    cmd(LATCH_CLEAR_CMD);
    stat(8'h00);
    hdr(LATCH_SET_CMD, 16'h0000);
    off();
    stat(8'h00);
  endtask
  task automatic t_page();
    wr(16'h1000, 24'h001122, 2);
    idle();
    wr(16'h107E, 24'hA1A2A3, 3);
    chk(8'(busy), 8'h01);
    stat(8'h01);
    hdr(READ_CMD, 16'h107E);
    snd(8'h00);
    chk(8'(so_oe_n), 8'h01);
    off();
    idle();
    stat(8'h00);
    rd(16'h107E, 24'h00A1A2, 2);
    rd(16'h1000, 24'h00A322, 2);
    // cut last byte: no commit
    cmd(LATCH_SET_CMD);
    hdr(WRITE_CMD, 16'h1000);
    u_spi_host_model.xfer(8'h55, 4, rx);
    off();
    chk(8'(busy), 8'h00);
    cmd(LATCH_CLEAR_CMD);
    rd(16'h1000, 24'h0000A3, 1);
  endtask
  task automatic t_wrap();
    wr(16'hFFFF, 24'h00005A, 1);
    idle();
    wr(16'h0000, 24'h0000C3, 1);
    idle();
    hdr(READ_CMD, 16'hFFFF);
    snd(8'h00);
    chk(rx, 8'h5A);
    u_spi_host_model.pause();
    snd(8'h00);
    chk(rx, 8'hC3);
    off();
  endtask
  task automatic t_status();
    swr(8'h8C);
    stat(8'h8C);
    @(posedge ref_clk_i) wp_n_i <= 1'b0;
    cmd(LATCH_SET_CMD);
    stat(8'h8E);
    swr(8'h00);
    cmd(LATCH_CLEAR_CMD);
    stat(8'h8C);
    @(posedge ref_clk_i) wp_n_i <= 1'b1;
    swr(8'h04);
    stat(8'h04);
    wr(16'hC000, 24'h000077, 1);
    chk(8'(busy), 8'h00);
    swr(8'h00);
    cmd(LATCH_CLEAR_CMD);
  endtask
  task automatic t_misc();
    logic [7:0] wipe [3] = '{PAGE_WIPE_CMD, SECTOR_WIPE_CMD, CHIP_WIPE_CMD};
    cmd(8'hFF);
    hdr(8'hFF, 16'h0000);
    chk(8'(so_oe_n), 8'h01);
    off();
    cmd(DEEP_SLEEP_CMD);
    hdr(READ_CMD, 16'h1000);
    snd(8'h00);
    chk(8'(so_oe_n), 8'h01);
    off();
    hdr(SIGNATURE_RELEASE_CMD, 16'h0000);
    snd(8'h00);
    snd(8'h00);
    chk(rx, SIG);
    off();
    foreach (wipe[i]) begin
      cmd(LATCH_SET_CMD);
      if (wipe[i] == CHIP_WIPE_CMD) cmd(wipe[i]);
      else hdr(wipe[i], 16'hFFFF);
      off();
      chk(8'(busy), 8'h01);
      idle();
    end
    rd(16'hFFFF, 24'hFFFFFF, 3);
  endtask
  initial begin
    fail_count = 0;
    cmp_count = 0;
    rst_i = 1'b1;
    wp_n_i = 1'b1;
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    t_latch();
    t_page();
    t_wrap();
    t_status();
    t_misc();
    stop_test();
  end
  // run is near 1 ms, mostly the chip wipe
  initial begin
    #1_300_000;
    fail_count++;
    stop_test();
  end
endmodule
